// ===== pwsb_pkg.sv
// Package with register offsets, field positions and reset values of the status bank.
package pwsb_pkg;
    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_OC_LIMIT = 8'h4A;
    localparam logic [7:0] CMD_OV_LIMIT = 8'h57;
    localparam logic [7:0] CMD_UV_LIMIT = 8'h58;
    localparam logic [7:0] CMD_OP_LIMIT = 8'h6B;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_CURRENT_STATUS = 8'h7B;
    localparam logic [7:0] CMD_INPUT_STATUS = 8'h7C;
    localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
    localparam logic [7:0] CMD_AUX_OV_LIMIT = 8'hDE;
    localparam logic [7:0] CMD_AUX_UV_LIMIT = 8'hDF;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] OP_LIMIT_RST = 16'h7FFF;
    localparam logic [11:0] OC_LIMIT_RST = 12'h7FF;
    localparam logic [11:0] OV_LIMIT_RST = 12'hFFF;
    localparam logic [11:0] UV_LIMIT_RST = 12'h000;
    localparam logic [11:0] AUX_OV_LIMIT_RST = 12'hFFF;
    localparam logic [11:0] AUX_UV_LIMIT_RST = 12'h000;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_OTHER_PENDING = 0;
    localparam int BIT_COMM_FAULT = 1;
    localparam int BIT_VENDOR_SUMMARY = 12;
    localparam int BIT_INPUT_SUMMARY = 13;
    localparam int BIT_CURRENT_SUMMARY = 14;
    localparam int BIT_OVERCURRENT = 5;
    localparam int BIT_PRIMARY_OV = 6;
    localparam int BIT_PRIMARY_UV = 5;
    localparam int BIT_OVERPOWER = 0;
    localparam int BIT_AUX_OV = 6;
    localparam int BIT_AUX_UV = 5;
endpackage

// ===== pwsb_cmp_if.sv
// Interface carrying one limit comparison between the bank and a comparator.
`timescale 1ns/1ns
interface pwsb_cmp_if #(
    parameter int W = 16
);
    logic signed [W-1:0] reading;
    logic signed [W-1:0] limit;
    logic trip;
    modport bank (output reading, output limit, input trip);
    modport cmp (input reading, input limit, output trip);
endinterface

// ===== pwsb_signed_cmp.sv
// Signed-direction limit comparator shared by the power and current checks.
`timescale 1ns/1ns
module pwsb_signed_cmp (
    pwsb_cmp_if.cmp port
);
    // A positive limit trips on a larger reading, a negative one on a more negative reading.
    wire lim_neg = port.limit[$bits(port.limit)-1];
    wire above = port.reading > port.limit;
    wire below = port.reading < port.limit;
    assign port.trip = lim_neg ? below : above; // see R1 // see R2 // see R18
endmodule

// ===== pwsb_bank.sv
// Warning and status register bank of the power monitor, with its limit checks.
`timescale 1ns/1ns
// What this block does
// R1 - Positive overpower limit trips when power reading is above it.
// R2 - Negative overpower limit trips when power reading is below it.
// R3 - Overpower limit is 16-bit read-write, resets to 0x7FFF.
// R4 - Status bit value one means the fault or warning occurred.
// R5 - Low byte of status word equals the status byte.
// R6 - Communication fault bit 1 latches on bad command, PEC or structure.
// R7 - Status byte bit 0 is live: any current, input or vendor warning bit active (not the comm fault bit).
// R8 - Status word bit 14 live while current warning register nonzero.
// R9 - Status word bit 13 live while input warning register nonzero.
// R10 - Status word bit 12 live while vendor warning register nonzero.
// R11 - Reserved status word and status byte bits read zero.
// R12 - Current warning bit 5 latches on overcurrent.
// R13 - Input warning bit 6 latches on primary overvoltage.
// R14 - Input warning bit 5 latches on primary undervoltage.
// R15 - Input warning bit 0 latches on overpower.
// R16 - Unused bits of detail status registers read zero.
// R17 - Clear-faults command clears all latched bits; persisting ones set again.
// R18 - Overcurrent limit sign chooses the tripping direction.
// R19 - Vendor register latches aux over and undervoltage in bits 6 and 5.
// R20 - Limits are checked once per completed monitor conversion.
// R21 - Reset clears every latched warning and fault bit.
module pwsb_bank (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic cmd_write_in,
    input wire logic cmd_read_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [15:0] cmd_wdata_in,
    input wire logic comm_error_in,
    input wire logic conv_done_in,
    input wire logic signed [11:0] sensed_current_in,
    input wire logic [11:0] primary_voltage_input_in,
    input wire logic [11:0] auxiliary_voltage_input_in,
    input wire logic signed [15:0] power_in,
    output logic [15:0] cmd_rdata_out,
    output logic cmd_ack_out,
    output logic other_status_pending_out
);
    // ------------------------------------------------------------------
    // Limit registers
    // ------------------------------------------------------------------
    logic [15:0] overpower_limit_r;
    logic [11:0] overcurrent_limit_r;
    logic [11:0] primary_overvoltage_limit_r;
    logic [11:0] primary_undervoltage_limit_r;
    logic [11:0] aux_ov_limit_r;
    logic [11:0] aux_uv_limit_r;

    wire wr_op = cmd_write_in && cmd_code_in == pwsb_pkg::CMD_OP_LIMIT;
    wire wr_oc = cmd_write_in && cmd_code_in == pwsb_pkg::CMD_OC_LIMIT;
    wire wr_ov = cmd_write_in && cmd_code_in == pwsb_pkg::CMD_OV_LIMIT;
    wire wr_uv = cmd_write_in && cmd_code_in == pwsb_pkg::CMD_UV_LIMIT;
    wire wr_aov = cmd_write_in && cmd_code_in == pwsb_pkg::CMD_AUX_OV_LIMIT;
    wire wr_auv = cmd_write_in && cmd_code_in == pwsb_pkg::CMD_AUX_UV_LIMIT;
    wire clear_cmd = cmd_write_in && cmd_code_in == pwsb_pkg::CMD_CLEAR_FAULTS;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            overpower_limit_r <= pwsb_pkg::OP_LIMIT_RST; // see R3
            overcurrent_limit_r <= pwsb_pkg::OC_LIMIT_RST;
            primary_overvoltage_limit_r <= pwsb_pkg::OV_LIMIT_RST;
            primary_undervoltage_limit_r <= pwsb_pkg::UV_LIMIT_RST;
            aux_ov_limit_r <= pwsb_pkg::AUX_OV_LIMIT_RST;
            aux_uv_limit_r <= pwsb_pkg::AUX_UV_LIMIT_RST;
        end else if (clk_en_in) begin
            if (wr_op) overpower_limit_r <= cmd_wdata_in; // see R3
            if (wr_oc) overcurrent_limit_r <= cmd_wdata_in[11:0];
            if (wr_ov) primary_overvoltage_limit_r <= cmd_wdata_in[11:0];
            if (wr_uv) primary_undervoltage_limit_r <= cmd_wdata_in[11:0];
            if (wr_aov) aux_ov_limit_r <= cmd_wdata_in[11:0];
            if (wr_auv) aux_uv_limit_r <= cmd_wdata_in[11:0];
        end
    end

    // ------------------------------------------------------------------
    // Comparisons
    // ------------------------------------------------------------------
    pwsb_cmp_if #(.W(16)) power_cmp ();
    pwsb_cmp_if #(.W(12)) current_cmp ();
    assign power_cmp.reading = power_in;
    assign power_cmp.limit = overpower_limit_r;
    assign current_cmp.reading = sensed_current_in;
    assign current_cmp.limit = overcurrent_limit_r;
    pwsb_signed_cmp u_power_cmp (.port(power_cmp));
    pwsb_signed_cmp u_current_cmp (.port(current_cmp));

    // Voltages are unsigned codes; a default limit disables its check naturally.
    wire ov_trip = primary_voltage_input_in > primary_overvoltage_limit_r;
    wire uv_trip = primary_voltage_input_in < primary_undervoltage_limit_r;
    wire aov_trip = auxiliary_voltage_input_in > aux_ov_limit_r;
    wire auv_trip = auxiliary_voltage_input_in < aux_uv_limit_r;

    // ------------------------------------------------------------------
    // Latched warning bits
    // ------------------------------------------------------------------
    logic overcurrent_warning_r;
    logic primary_overvoltage_warning_r;
    logic primary_undervoltage_warning_r;
    logic overpower_warning_r;
    logic aux_overvoltage_warning_r;
    logic aux_undervoltage_warning_r;
    logic comm_fault_flag_r;

    // A new event wins over a clear in the same cycle so it is never lost.
    wire [6:0] set_vec = {comm_error_in, {6{conv_done_in}} &
        {auv_trip, aov_trip, power_cmp.trip, uv_trip, ov_trip, current_cmp.trip}}; // see R20
    wire [6:0] flag_now = {comm_fault_flag_r, aux_undervoltage_warning_r,
        aux_overvoltage_warning_r, overpower_warning_r, primary_undervoltage_warning_r,
        primary_overvoltage_warning_r, overcurrent_warning_r};
    wire [6:0] flag_nxt = set_vec | (flag_now & {7{!clear_cmd}}); // see R17

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            {comm_fault_flag_r, aux_undervoltage_warning_r, aux_overvoltage_warning_r,
                overpower_warning_r, primary_undervoltage_warning_r,
                primary_overvoltage_warning_r, overcurrent_warning_r} <= 7'h00; // see R21
        end else if (clk_en_in) begin
            // see R6 see R12 see R13 see R14 see R15 see R19
            {comm_fault_flag_r, aux_undervoltage_warning_r, aux_overvoltage_warning_r,
                overpower_warning_r, primary_undervoltage_warning_r,
                primary_overvoltage_warning_r, overcurrent_warning_r} <= flag_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Register images and read decode
    // ------------------------------------------------------------------
    wire [7:0] current_warning_register = {2'b00, overcurrent_warning_r, 5'b00000}; // see R16
    wire [7:0] input_warning_register = {1'b0, primary_overvoltage_warning_r,
        primary_undervoltage_warning_r, 4'b0000, overpower_warning_r}; // see R16 see R4
    wire [7:0] vendor_warning_register = {1'b0, aux_overvoltage_warning_r,
        aux_undervoltage_warning_r, 5'b00000}; // see R19
    wire current_summary_flag = |current_warning_register; // see R8
    wire input_summary_flag = |input_warning_register; // see R9
    wire vendor_summary_flag = |vendor_warning_register; // see R10
    wire other_status_pending = current_summary_flag | input_summary_flag
        | vendor_summary_flag; // see R7
    wire [7:0] top_status_byte = {6'b000000, comm_fault_flag_r, other_status_pending}; // see R11
    wire [15:0] top_status_word = {1'b0, current_summary_flag, input_summary_flag,
        vendor_summary_flag, 4'b0000, top_status_byte}; // see R5 see R11

    logic [15:0] rd_mux;
    always_comb begin
        unique case (cmd_code_in)
            pwsb_pkg::CMD_OP_LIMIT: rd_mux = overpower_limit_r;
            pwsb_pkg::CMD_OC_LIMIT: rd_mux = {4'h0, overcurrent_limit_r};
            pwsb_pkg::CMD_OV_LIMIT: rd_mux = {4'h0, primary_overvoltage_limit_r};
            pwsb_pkg::CMD_UV_LIMIT: rd_mux = {4'h0, primary_undervoltage_limit_r};
            pwsb_pkg::CMD_AUX_OV_LIMIT: rd_mux = {4'h0, aux_ov_limit_r};
            pwsb_pkg::CMD_AUX_UV_LIMIT: rd_mux = {4'h0, aux_uv_limit_r};
            pwsb_pkg::CMD_STATUS_BYTE: rd_mux = {8'h00, top_status_byte};
            pwsb_pkg::CMD_STATUS_WORD: rd_mux = top_status_word;
            pwsb_pkg::CMD_CURRENT_STATUS: rd_mux = {8'h00, current_warning_register};
            pwsb_pkg::CMD_INPUT_STATUS: rd_mux = {8'h00, input_warning_register};
            pwsb_pkg::CMD_VENDOR_STATUS: rd_mux = {8'h00, vendor_warning_register};
            default: rd_mux = 16'h0000;
        endcase
    end

    // Outputs are registered, so a read answers one enabled cycle after it is taken.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cmd_rdata_out <= 16'h0000;
            cmd_ack_out <= 1'b0;
            other_status_pending_out <= 1'b0;
        end else if (clk_en_in) begin
            if (cmd_read_in) cmd_rdata_out <= rd_mux;
            cmd_ack_out <= cmd_read_in;
            other_status_pending_out <= |flag_nxt[5:0]; // see R7
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_OP_LATCH: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R15
        clk_en_in && conv_done_in && power_cmp.trip |=> overpower_warning_r)
        else $error("overpower not latched");
    AST_OP_SIGN: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R2
        overpower_limit_r[15] && ($signed(power_in) < $signed(overpower_limit_r))
        |-> power_cmp.trip)
        else $error("negative overpower limit missed");
    AST_OC_LATCH: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R12
        clk_en_in && conv_done_in && current_cmp.trip |=> overcurrent_warning_r)
        else $error("overcurrent not latched");
    AST_UV_LATCH: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R14
        clk_en_in && conv_done_in && uv_trip |=> primary_undervoltage_warning_r)
        else $error("undervoltage not latched");
    AST_COMM_LATCH: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R6
        clk_en_in && comm_error_in |=> comm_fault_flag_r)
        else $error("comm fault not latched");
    AST_CLEAR: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R17
        clk_en_in && clear_cmd && !comm_error_in && !conv_done_in |=> flag_now == 7'h00)
        else $error("clear faults did not clear");
    AST_HOLD: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R13
        primary_overvoltage_warning_r && !clear_cmd |=> primary_overvoltage_warning_r)
        else $error("warning not held");
    AST_WORD_LOW: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R5
        clk_en_in && cmd_read_in && cmd_code_in == pwsb_pkg::CMD_STATUS_WORD
        |=> cmd_ack_out && cmd_rdata_out[7:0] == $past(top_status_byte)
            && cmd_rdata_out[15] == 1'b0 && cmd_rdata_out[11:8] == 4'h0)
        else $error("status word low byte mismatch");
    AST_SUMMARY: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R7
        clk_en_in && !clear_cmd && (aux_overvoltage_warning_r || aux_undervoltage_warning_r)
        |=> other_status_pending_out)
        else $error("pending summary wrong");
    AST_OP_DEFAULT: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see R1
        overpower_limit_r == pwsb_pkg::OP_LIMIT_RST |-> !power_cmp.trip)
        else $error("default overpower limit tripped");

    COV_OP: cover property (@(posedge clock_in) overpower_warning_r);
    COV_COMM: cover property (@(posedge clock_in) comm_fault_flag_r ##1 !comm_fault_flag_r);
    COV_AUX: cover property (@(posedge clock_in) aux_overvoltage_warning_r);
    COV_CLEAR_SET: cover property (@(posedge clock_in) clk_en_in && clear_cmd && comm_error_in);
    COV_NEG_OC: cover property (@(posedge clock_in) overcurrent_limit_r[11] && overcurrent_warning_r);

    // ------------------------------------------------------------------
    // Latch, comparator, read image, limit write and reset checks
    // ------------------------------------------------------------------
    wire rd_word = clk_en_in && cmd_read_in && cmd_code_in == pwsb_pkg::CMD_STATUS_WORD;
    wire rd_byte = clk_en_in && cmd_read_in && cmd_code_in == pwsb_pkg::CMD_STATUS_BYTE;
    wire rd_cur = clk_en_in && cmd_read_in && cmd_code_in == pwsb_pkg::CMD_CURRENT_STATUS;
    wire rd_in = clk_en_in && cmd_read_in && cmd_code_in == pwsb_pkg::CMD_INPUT_STATUS;
    wire rd_ven = clk_en_in && cmd_read_in && cmd_code_in == pwsb_pkg::CMD_VENDOR_STATUS;
    AST_OV_LATCH: assert property ( // see R13
        @(posedge clock_in) disable iff (sys_rst_in)
        clk_en_in && conv_done_in && ov_trip |=> primary_overvoltage_warning_r)
        else $error("overvoltage not latched");
    AST_AOV_LATCH: assert property ( // see R19
        @(posedge clock_in) disable iff (sys_rst_in)
        clk_en_in && conv_done_in && aov_trip |=> aux_overvoltage_warning_r)
        else $error("aux overvoltage not latched");
    AST_AUV_LATCH: assert property ( // see R19
        @(posedge clock_in) disable iff (sys_rst_in)
        clk_en_in && conv_done_in && auv_trip |=> aux_undervoltage_warning_r)
        else $error("aux undervoltage not latched");
    AST_OP_POS: assert property ( // see R1
        @(posedge clock_in) disable iff (sys_rst_in)
        !overpower_limit_r[15] && power_in > $signed(overpower_limit_r) |-> power_cmp.trip)
        else $error("positive overpower limit missed");
    AST_OC_NEG: assert property ( // see R18
        @(posedge clock_in) disable iff (sys_rst_in) overcurrent_limit_r[11]
        && sensed_current_in < $signed(overcurrent_limit_r) |-> current_cmp.trip)
        else $error("negative overcurrent limit missed");
    AST_OC_POS: assert property ( // see R18
        @(posedge clock_in) disable iff (sys_rst_in) !overcurrent_limit_r[11]
        && sensed_current_in > $signed(overcurrent_limit_r) |-> current_cmp.trip)
        else $error("positive overcurrent limit missed");
    AST_NO_CONV: assert property ( // see R20
        @(posedge clock_in) disable iff (sys_rst_in)
        !conv_done_in && !overpower_warning_r |=> !overpower_warning_r)
        else $error("warning set without conversion");
    AST_WORD_CUR: assert property ( // see R8
        @(posedge clock_in) disable iff (sys_rst_in)
        rd_word && overcurrent_warning_r |=> cmd_rdata_out[14])
        else $error("current summary missing");
    AST_WORD_IN: assert property ( // see R9
        @(posedge clock_in) disable iff (sys_rst_in) rd_word &&
        (primary_overvoltage_warning_r || primary_undervoltage_warning_r || overpower_warning_r)
        |=> cmd_rdata_out[13])
        else $error("input summary missing");
    AST_WORD_VEN: assert property ( // see R10
        @(posedge clock_in) disable iff (sys_rst_in)
        rd_word && (aux_overvoltage_warning_r || aux_undervoltage_warning_r) |=> cmd_rdata_out[12])
        else $error("vendor summary missing");
    AST_WORD_IDLE: assert property ( // see R7
        @(posedge clock_in) disable iff (sys_rst_in)
        rd_word && flag_now == 7'h00 |=> cmd_rdata_out == 16'h0000)
        else $error("idle status word not zero");
    AST_BYTE_PEND: assert property ( // see R7
        @(posedge clock_in) disable iff (sys_rst_in)
        rd_byte && overcurrent_warning_r |=> cmd_rdata_out[0])
        else $error("status byte pending bit missing");
    AST_BYTE_RSV: assert property ( // see R11
        @(posedge clock_in) disable iff (sys_rst_in)
        rd_byte |=> cmd_rdata_out[15:2] == 14'h0000)
        else $error("status byte reserved bits set");
    AST_CUR_RSV: assert property ( // see R16
        @(posedge clock_in) disable iff (sys_rst_in)
        rd_cur |=> cmd_rdata_out[15:6] == 10'h000 && cmd_rdata_out[4:0] == 5'h00)
        else $error("current status unused bits set");
    AST_IN_RSV: assert property ( // see R16
        @(posedge clock_in) disable iff (sys_rst_in)
        rd_in |=> cmd_rdata_out[15:7] == 9'h000 && cmd_rdata_out[4:1] == 4'h0)
        else $error("input status unused bits set");
    AST_VEN_RSV: assert property ( // see R19
        @(posedge clock_in) disable iff (sys_rst_in)
        rd_ven |=> cmd_rdata_out[15:7] == 9'h000 && cmd_rdata_out[4:0] == 5'h00)
        else $error("vendor status unused bits set");
    AST_OP_WRITE: assert property ( // see R3
        @(posedge clock_in) disable iff (sys_rst_in)
        clk_en_in && wr_op |=> overpower_limit_r == $past(cmd_wdata_in))
        else $error("overpower limit write lost");
    AST_OP_KEEP: assert property ( // see R3
        @(posedge clock_in) disable iff (sys_rst_in)
        clk_en_in && !wr_op |=> $stable(overpower_limit_r))
        else $error("overpower limit changed unasked");
    AST_COMM_HOLD: assert property ( // see R6
        @(posedge clock_in) disable iff (sys_rst_in)
        comm_fault_flag_r && !clear_cmd |=> comm_fault_flag_r)
        else $error("comm fault not held");
    AST_RESET: assert property ( // see R21
        @(posedge clock_in) sys_rst_in |=> flag_now == 7'h00 && !cmd_ack_out
        && !other_status_pending_out && overpower_limit_r == pwsb_pkg::OP_LIMIT_RST)
        else $error("reset left state behind");
endmodule

// ===== pwsb_host_model.sv
// Host controller model that issues register commands to the status bank.
`timescale 1ns/1ns
module pwsb_host_model (
    input wire logic clock_in,
    input wire logic ack_in,
    input wire logic [15:0] rdata_in,
    output logic write_out,
    output logic read_out,
    output logic [7:0] code_out,
    output logic [15:0] wdata_out
);
    initial begin
        write_out = 1'b0;
        read_out = 1'b0;
        code_out = 8'h00;
        wdata_out = 16'h0000;
    end
    // ------------------------------------------------------------------
    // Command tasks
    // ------------------------------------------------------------------
    // Released fields carry their inverse, so a stale code is never taken for a live one.
    task automatic put(input logic [7:0] code, input logic [15:0] data);
        @(negedge clock_in);
        write_out = 1'b1;
        code_out = code;
        wdata_out = data;
        @(negedge clock_in);
        write_out = 1'b0;
        code_out = ~code;
        wdata_out = ~data;
    endtask
    // The clear command carries no data bytes, so the data field is left at zero.
    task automatic clear_faults();
        put(pwsb_pkg::CMD_CLEAR_FAULTS, 16'h0000);
    endtask
    task automatic get(input logic [7:0] code, output logic [15:0] data, output logic ok);
        int n;
        @(negedge clock_in);
        read_out = 1'b1;
        code_out = code;
        @(negedge clock_in);
        read_out = 1'b0;
        code_out = ~code;
        n = 0;
        while (ack_in !== 1'b1 && n < 4) begin
            @(negedge clock_in);
            n++;
        end
        ok = (ack_in === 1'b1);
        data = rdata_in;
    endtask
endmodule

// ===== testbench.sv
// Self-checking testbench for the warning and status register bank.
`timescale 1ns/1ns
module testbench;
    typedef struct {
        logic [7:0] lc;
        logic [15:0] lv;
        logic [11:0] c, v, a;
        logic [15:0] p;
        logic [7:0] sc;
        logic [15:0] se, we;
    } pwsb_row_s;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic comm_error_in = 1'b0;
    logic conv_done_in = 1'b0;
    logic [11:0] cur = 12'h000, primary_voltage_input = 12'h400, aux = 12'h400;
    logic [15:0] pwr = 16'h0000;
    logic cmd_write_in, cmd_read_in, cmd_ack_out, other_status_pending_out;
    logic [7:0] cmd_code_in;
    logic [15:0] cmd_wdata_in, cmd_rdata_out;
    int miscompares = 0;
    int checked = 0;
    logic [7:0] rc [12] = '{8'h6b, 8'h4a, 8'h57, 8'h58, 8'hde, 8'hdf,
                            8'h78, 8'h79, 8'h7b, 8'h7c, 8'h80, 8'h10};
    logic [15:0] rv [12] = '{16'h7fff, 16'h07ff, 16'h0fff, 16'h0000, 16'h0fff, 16'h0000,
                             16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    // Limits accumulate from row to row; the idle readings stay clear of every limit.
    pwsb_row_s rows [12] = '{
        '{8'h6b, 16'h0100, 12'h000, 12'h400, 12'h400, 16'h0100, 8'h7c, 16'h0000, 16'h0000},
        '{8'h6b, 16'h0100, 12'h000, 12'h400, 12'h400, 16'h0101, 8'h7c, 16'h0001, 16'h2001},
        '{8'h6b, 16'hff00, 12'h000, 12'h400, 12'h400, 16'h7000, 8'h7c, 16'h0000, 16'h0000},
        '{8'h6b, 16'hff00, 12'h000, 12'h400, 12'h400, 16'hfeff, 8'h7c, 16'h0001, 16'h2001},
        '{8'h4a, 16'h0100, 12'h101, 12'h400, 12'h400, 16'h0000, 8'h7b, 16'h0020, 16'h4001},
        '{8'h4a, 16'h0f00, 12'h7ff, 12'h400, 12'h400, 16'h0000, 8'h7b, 16'h0000, 16'h0000},
        '{8'h4a, 16'h0f00, 12'heff, 12'h400, 12'h400, 16'h0000, 8'h7b, 16'h0020, 16'h4001},
        '{8'h57, 16'h0800, 12'h000, 12'h800, 12'h400, 16'h0000, 8'h7c, 16'h0000, 16'h0000},
        '{8'h57, 16'h0800, 12'h000, 12'h801, 12'h400, 16'h0000, 8'h7c, 16'h0040, 16'h2001},
        '{8'h58, 16'h0100, 12'h000, 12'h0ff, 12'h400, 16'h0000, 8'h7c, 16'h0020, 16'h2001},
        '{8'hde, 16'h0800, 12'h000, 12'h400, 12'h801, 16'h0000, 8'h80, 16'h0040, 16'h1001},
        '{8'hdf, 16'h0100, 12'h000, 12'h400, 12'h0ff, 16'h0000, 8'h80, 16'h0020, 16'h1001}};
    always #20 clock_in = ~clock_in;
    pwsb_bank i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
        .cmd_write_in(cmd_write_in), .cmd_read_in(cmd_read_in), .cmd_code_in(cmd_code_in),
        .cmd_wdata_in(cmd_wdata_in), .comm_error_in(comm_error_in),
        .conv_done_in(conv_done_in), .sensed_current_in(cur),
        .primary_voltage_input_in(primary_voltage_input), .auxiliary_voltage_input_in(aux), .power_in(pwr),
        .cmd_rdata_out(cmd_rdata_out), .cmd_ack_out(cmd_ack_out),
        .other_status_pending_out(other_status_pending_out));
    pwsb_host_model i_host (.clock_in(clock_in), .ack_in(cmd_ack_out),
        .rdata_in(cmd_rdata_out), .write_out(cmd_write_in), .read_out(cmd_read_in),
        .code_out(cmd_code_in), .wdata_out(cmd_wdata_in));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        i_host.get(code, d, ok);
        chk("read ack", 16'h0001, {15'h0000, ok});
        chk($sformatf("register %h", code), exp, d);
    endtask
    // Readings are scrambled after the strobe, since they mean nothing outside it.
    task automatic conv(input logic [11:0] c, v, a, input logic [15:0] p);
        @(negedge clock_in);
        {cur, primary_voltage_input, aux, pwr, conv_done_in} = {c, v, a, p, 1'b1};
        @(negedge clock_in);
        {cur, primary_voltage_input, aux, pwr, conv_done_in} = {~c, ~v, ~a, ~p, 1'b0};
    endtask
    task automatic finish_test();
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(negedge clock_in);
        sys_rst_in = 1'b0;
        foreach (rc[i]) rd(rc[i], rv[i]);
        i_host.put(8'h79, 16'hffff);
        rd(8'h79, 16'h0000);
        i_host.put(8'h6b, 16'h1234);
        rd(8'h6b, 16'h1234);
        @(negedge clock_in);
        comm_error_in = 1'b1;
        @(negedge clock_in);
        comm_error_in = 1'b0;
        rd(8'h78, 16'h0002);
        rd(8'h79, 16'h0002);
        chk("pending", 16'h0000, {15'h0000, other_status_pending_out});
        i_host.clear_faults();
        rd(8'h78, 16'h0000);
        fork
            i_host.clear_faults();
            begin
                @(negedge clock_in);
                comm_error_in = 1'b1;
                @(negedge clock_in);
                comm_error_in = 1'b0;
            end
        join
        rd(8'h78, 16'h0002);
        i_host.clear_faults();
        clk_en_in = 1'b0;
        conv(12'h000, 12'h400, 12'h400, 16'h7fff);
        i_host.put(8'h6b, 16'h5555);
        clk_en_in = 1'b1;
        rd(8'h7c, 16'h0000);
        rd(8'h6b, 16'h1234);
        foreach (rows[i]) begin
            i_host.put(rows[i].lc, rows[i].lv);
            conv(rows[i].c, rows[i].v, rows[i].a, rows[i].p);
            rd(rows[i].sc, rows[i].se);
            rd(8'h79, rows[i].we);
            rd(8'h78, {8'h00, rows[i].we[7:0]});
            chk("pending", 16'(rows[i].we[0]), 16'(other_status_pending_out));
            i_host.clear_faults();
            rd(rows[i].sc, 16'h0000);
        end
        conv(12'h000, 12'h400, 12'h400, 16'h8000);
        rd(8'h7c, 16'h0001);
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clock_in);
        sys_rst_in = 1'b0;
        rd(8'h7c, 16'h0000);
        rd(8'h6b, 16'h7fff);
        chk("pending", 16'h0000, 16'(other_status_pending_out));
        finish_test();
    end
    initial begin
        #(40 * 5000);
        miscompares++;
        finish_test();
    end
endmodule
